// ---- hw/dac_module_command_engine.sv ----
// Overview of operation
// RULE_01 - after reset wait for commands, preload allowed, no DAC output
// RULE_02 - run command enters running, starts output and periodic replies
// RULE_03 - halt command stops output and replies, returns to wait silently
// RULE_04 - reset command reinitialises all, clears FIFO, sends identifier
// RULE_05 - controller sends halt before any reset
// RULE_06 - eeprom access executed with reply only while waiting
// RULE_07 - eeprom reply first byte 01100000, last bit carries read bit
// RULE_08 - settings command stores options and divisor only while waiting
// RULE_09 - sample period is (64 minus divisor) base ticks per output
// RULE_10 - channel count select picks one, two, four or eight channels
// RULE_11 - external trigger start waits for falling trigger edge
// RULE_12 - controller sends one sample per active channel per group
// RULE_13 - ring mode loops FIFO output back, no refills while running
// RULE_14 - reply type zero echoes each sample, one reports every 1024
// RULE_15 - fifo clear bit empties the sample FIFO
// RULE_16 - data word preloads FIFO while waiting, refills while running
// RULE_17 - identifier reply carries firmware version and module id
// RULE_18 - fill report carries level in kilosamples and error flags
// RULE_19 - one fill report after every 1K samples read
// RULE_20 - echo reply returns sample, channel code and error flags
// RULE_21 - underrun flag on empty FIFO during output, outputs hold
// RULE_22 - overflow flag when sample meets full FIFO, sample dropped; code sets the flag only while running, not while waiting or armed
// RULE_23 - one shared FIFO serves as stream buffer or looped ring
// RULE_24 - while running only samples, halt and reset are acted on
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_defs.svh"
module dac_module_command_engine
    import dac_cmd_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [`WORD_W:0] cmd_word,
    output logic reply_valid,
    input wire logic reply_ready,
    output logic [`WORD_W:0] reply_word,
    input wire logic trigger_in,
    output logic eeprom_strobe,
    output logic [1:0] eeprom_bits,
    input wire logic eeprom_read_bit,
    output logic dac_strobe,
    output logic [2:0] dac_channel,
    output logic [`SAMPLE_W-1:0] dac_value,
    output logic running
);
    localparam int FW = `SAMPLE_W + 3;
    typedef struct packed {
        mode_e mode;
        logic [1:0] chan_sel;
        logic report_mode;
        logic ring;
        logic ext_trig;
        logic [7:0] divisor;
        logic [5:0] base_cnt;
        logic [5:0] rate_cnt;
        logic [3:0] slot;
        logic [10:0] read_cnt;
        logic underrun;
        logic overflow;
        logic trig_prev;
        logic pend;
        logic [`WORD_W:0] pend_word;
        logic [`WORD_W:0] reply;
        logic rvalid;
        logic ee;
        logic [1:0] ee_bits;
        logic strobe;
        logic [2:0] chan;
        logic [`SAMPLE_W-1:0] value;
    } state_s;
    state_s r;
    state_s next_r;
    logic flush;
    logic f_in_valid;
    logic f_in_ready;
    logic [FW-1:0] f_in_data;
    logic f_out_valid;
    logic f_out_ready;
    logic [FW-1:0] f_out_data;
    logic [`FIFO_AW:0] f_level;
    cmd_e cmd;
    logic tick;
    logic pop;
    function automatic cmd_e decode(input logic [`WORD_W:0] w);
        logic [7:0] b1;
        b1 = w[`B1_MSB:`B1_MSB-7];
        if (!w[`WORD_W]) begin
            decode = (b1[7:4] == 4'h0 && !b1[0]) ? cmd_sample : cmd_none;
        end else if (b1[7:6] == 2'h0) begin
            decode = cmd_halt;
        end else if (b1[7:6] == 2'h2) begin
            decode = cmd_reset;
        end else if (b1[7:2] == 6'h18 && w[`B2_MSB:0] == 24'h0) begin
            decode = cmd_eeprom;
        end else if (b1 == 8'he0) begin
            decode = cmd_settings;
        end else if (b1[7:5] == 3'h6) begin
            decode = cmd_run;
        end else begin
            decode = cmd_none;
        end
    endfunction : decode
    function automatic logic [4:0] group_size(input logic [1:0] sel);
        group_size = 5'h1 << sel;
    endfunction : group_size
    assign cmd = decode(cmd_word);
    // RULE_04 reset clears fifo
    assign flush = cmd_valid && cmd_ready
        && (cmd == cmd_reset
        // RULE_15 clear bit flushes
        || (cmd == cmd_settings && r.mode == st_wait
        && cmd_word[`B2_MSB-4]));
    // reply slot must be free before any word is taken
    assign cmd_ready = !r.rvalid || reply_ready;
    assign tick = r.mode == st_run && r.base_cnt == `BASE_DIV_CYC - 1'b1
        && r.rate_cnt == 6'h0;
    // RULE_13 ring loops output
    assign f_out_ready = tick;
    assign pop = tick && f_out_valid;
    always_comb begin
        f_in_valid = 1'b0;
        f_in_data = {cmd_word[`B1_MSB-4:`B1_MSB-6], cmd_word[15:0]};
        if (pop && r.ring) begin
            f_in_valid = 1'b1;
            f_in_data = f_out_data;
        end else if (cmd_valid && cmd_ready && cmd == cmd_sample
            // RULE_16 preload or refill
            && !(r.ring && r.mode != st_wait)) begin
            f_in_valid = 1'b1;
        end
    end
    // RULE_23 shared sample fifo
    sample_fifo #(.WIDTH(FW), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
        .clock(clock),
        .rst(rst),
        .flush(flush),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data),
        .level(f_level)
    );
    always_comb begin
        next_r = r;
        next_r.ee = 1'b0;
        next_r.strobe = 1'b0;
        next_r.trig_prev = trigger_in;
        if (r.rvalid && reply_ready) begin
            next_r.rvalid = 1'b0;
        end
        // pending status reply moves into the free slot
        if (r.pend && !next_r.rvalid) begin
            next_r.pend = 1'b0;
            next_r.rvalid = 1'b1;
            next_r.reply = r.pend_word;
        end
        if (r.mode == st_run) begin
            next_r.base_cnt = r.base_cnt + 1'b1;
            if (r.base_cnt == `BASE_DIV_CYC - 1'b1) begin
                next_r.base_cnt = '0;
                // RULE_09 divisor sets period
                next_r.rate_cnt = (r.rate_cnt == 6'h0)
                    ? 6'(`DIV_LIMIT - r.divisor[5:0] - 1'b1)
                    : r.rate_cnt - 1'b1;
            end
        end
        if (tick) begin
            // RULE_10 group slots
            next_r.slot = (r.slot + 1'b1 == 4'(group_size(r.chan_sel)))
                ? 4'h0 : r.slot + 1'b1;
            if (!f_out_valid) begin
                // RULE_21 underrun holds outputs
                next_r.underrun = 1'b1;
            end
        end
        if (pop) begin
            next_r.strobe = 1'b1;
            next_r.chan = f_out_data[FW-1:`SAMPLE_W];
            next_r.value = f_out_data[`SAMPLE_W-1:0];
            next_r.read_cnt = r.read_cnt + 1'b1;
            if (!r.report_mode) begin
                // RULE_14 echo each sample
                // RULE_20 echo format
                next_r.pend = 1'b1;
                next_r.pend_word = {1'b1, `RPL_ECHO, r.underrun,
                    f_out_data[FW-1:`SAMPLE_W], r.overflow, 8'h00,
                    f_out_data[`SAMPLE_W-1:0]};
                next_r.underrun = 1'b0;
                next_r.overflow = 1'b0;
            // RULE_19 report every 1K
            end else if (r.read_cnt + 1'b1 == `REPLY_PERIOD) begin
                next_r.read_cnt = '0;
                // RULE_18 fill report format
                next_r.pend = 1'b1;
                next_r.pend_word = {1'b1, `RPL_FILL, r.underrun, 3'h0,
                    r.overflow, 12'h000, 12'(f_level >> 10)};
                next_r.underrun = 1'b0;
                next_r.overflow = 1'b0;
            end
        end
        // RULE_22 overflow drops sample
        if (cmd_valid && cmd_ready && cmd == cmd_sample && r.mode == st_run
            && !r.ring && !f_in_ready) begin
            next_r.overflow = 1'b1;
        end
        // RULE_11 falling trigger edge
        if (r.mode == st_arm && r.trig_prev && !trigger_in) begin
            next_r.mode = st_run;
        end
        if (cmd_valid && cmd_ready) begin
            unique case (cmd)
                // RULE_03 halt silently
                cmd_halt: begin
                    next_r.mode = st_wait;
                    next_r.pend = 1'b0;
                end
                // RULE_04 identifier reply
                cmd_reset: begin
                    next_r = '0;
                    next_r.trig_prev = trigger_in;
                    next_r.rvalid = 1'b1;
                    // RULE_17 identifier format
                    next_r.reply = {1'b1, `RPL_IDENT, `FW_VERSION,
                        `MODULE_ID, `MODULE_ID, 8'h00};
                end
                // RULE_06 eeprom only waiting
                cmd_eeprom: if (r.mode == st_wait) begin
                    next_r.ee = 1'b1;
                    next_r.ee_bits = cmd_word[`B1_MSB-6:`B1_MSB-7];
                    // RULE_07 eeprom reply
                    next_r.rvalid = 1'b1;
                    next_r.reply = {1'b1, `RPL_EEPROM, 23'h0,
                        eeprom_read_bit};
                end
                // RULE_08 settings when waiting
                cmd_settings: if (r.mode == st_wait) begin
                    next_r.chan_sel = cmd_word[`B2_MSB:`B2_MSB-1];
                    next_r.report_mode = cmd_word[`B2_MSB-5];
                    next_r.ring = cmd_word[`B2_MSB-6];
                    next_r.ext_trig = cmd_word[`B2_MSB-7];
                    next_r.divisor = (cmd_word[`B3_MSB:`B3_MSB-7] > `DIV_MAX)
                        ? `DIV_MAX : cmd_word[`B3_MSB:`B3_MSB-7];
                end
                // RULE_02 run starts output
                cmd_run: if (r.mode == st_wait) begin
                    next_r.mode = r.ext_trig ? st_arm : st_run;
                    next_r.base_cnt = '0;
                    next_r.rate_cnt = '0;
                    next_r.slot = '0;
                    next_r.read_cnt = '0;
                    next_r.underrun = 1'b0;
                    next_r.overflow = 1'b0;
                end
                // RULE_24 others ignored
                default: begin
                end
            endcase
        end
    end
    // RULE_01 reset to waiting
    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign reply_valid = r.rvalid;
    assign reply_word = r.reply;
    assign eeprom_strobe = r.ee;
    assign eeprom_bits = r.ee_bits;
    assign dac_strobe = r.strobe;
    assign dac_channel = r.chan;
    assign dac_value = r.value;
    assign running = r.mode == st_run;
endmodule : dac_module_command_engine
`default_nettype wire

// ---- hw/sample_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic push;
    logic pop;
    // a pop in the same cycle frees the slot a looped sample needs
    assign in_ready = !flush
        && (level != (AW+1)'(DEPTH) || (out_ready && level != '0));
    assign out_valid = (level != '0) && !flush;
    assign out_data = mem[rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clock) begin
        if (rst || flush) begin
            rd <= '0;
            wr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                mem[wr] <= in_data;
                wr <= wr + 1'b1;
            end
            if (pop) begin
                rd <= rd + 1'b1;
            end
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sample_fifo
`default_nettype wire

// ---- pkg/dac_cmd_defs.svh ----
`ifndef DAC_CMD_DEFS_SVH
`define DAC_CMD_DEFS_SVH
`define WORD_W 32
`define SAMPLE_W 16
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define REPLY_PERIOD 11'h400
`define BASE_DIV_CYC 6'h32
`define DIV_LIMIT 7'h40
`define DIV_MAX 8'h3c
// arbitrary firmware version value
`define FW_VERSION 6'h01
// arbitrary module identifier value
`define MODULE_ID 8'h5a
`define RPL_IDENT 2'h2
`define RPL_EEPROM 8'h60
`define RPL_FILL 3'h6
`define RPL_ECHO 3'h7
`define B1_MSB 31
`define B2_MSB 23
`define B3_MSB 15
`endif

// ---- pkg/dac_cmd_pkg.sv ----
`include "dac_cmd_defs.svh"
package dac_cmd_pkg;
    typedef enum logic [1:0] {st_wait, st_arm, st_run} mode_e;
    typedef enum logic [2:0] {
        cmd_none, cmd_halt, cmd_reset, cmd_eeprom, cmd_settings, cmd_run,
        cmd_sample
    } cmd_e;
endpackage : dac_cmd_pkg

// ---- testbench/controller_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module controller_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic stall,
    input wire logic reply_valid,
    input wire logic [32:0] reply_word,
    output logic reply_ready,
    output logic [32:0] last_reply,
    output int reply_count
);
    // reply taken only at an edge where ready is high
    always_ff @(posedge clock) begin
        if (rst) begin
            reply_ready <= 1'b0;
            reply_count <= 0;
            last_reply <= '0;
        end else begin
            reply_ready <= !stall;
            if (reply_valid && reply_ready) begin
                last_reply <= reply_word;
                reply_count <= reply_count + 1;
            end
        end
    end
endmodule : controller_model
`default_nettype wire

// ---- testbench/engine_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_defs.svh"
module engine_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [`WORD_W:0] cmd_word,
    input wire logic reply_valid,
    input wire logic reply_ready,
    input wire logic [`WORD_W:0] reply_word,
    input wire logic eeprom_strobe,
    input wire logic eeprom_read_bit,
    input wire logic dac_strobe,
    input wire logic [2:0] dac_channel,
    input wire logic [`SAMPLE_W-1:0] dac_value,
    input wire logic running
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire logic take = cmd_valid && cmd_ready && cmd_word[32];
    a_ident_reply: assert property (take && cmd_word[31:30] == 2'h2
        |=> reply_valid && reply_word[32:16] ==
        {1'b1, `RPL_IDENT, `FW_VERSION, `MODULE_ID}) else $error("bad ident");
    a_eeprom_reply: assert property (eeprom_strobe |-> reply_valid
        && reply_word[32:16] == 17'h16000
        && reply_word[0] == $past(eeprom_read_bit)) else $error("bad eeprom");
    a_eeprom_idle: assert property (eeprom_strobe |-> !running)
        else $error("eeprom while running");
    a_reply_hold: assert property (reply_valid && !reply_ready
        |=> reply_valid && $stable(reply_word)) else $error("reply dropped");
    a_ready_block: assert property (reply_valid && !reply_ready
        |-> !cmd_ready) else $error("ready while reply held");
    a_echo_match: assert property (reply_valid && reply_word[31:29] == 3'h7
        |-> reply_word[27:25] == dac_channel
        && reply_word[15:0] == dac_value) else $error("echo mismatch");
    a_strobe_gap: assert property (dac_strobe |=> !dac_strobe [*8])
        else $error("strobe too soon");
    a_halt_stop: assert property (take && cmd_word[31:30] == 2'h0
        |=> !running) else $error("still running");
    cover property (eeprom_strobe);
    cover property (dac_strobe && running);
    cover property (reply_valid && !reply_ready);
endmodule : engine_props
bind dac_module_command_engine engine_props props (.clock(clock), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
    .reply_valid(reply_valid), .reply_ready(reply_ready),
    .reply_word(reply_word), .eeprom_strobe(eeprom_strobe),
    .eeprom_read_bit(eeprom_read_bit), .dac_strobe(dac_strobe),
    .dac_channel(dac_channel), .dac_value(dac_value), .running(running));
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_defs.svh"
module tb_top;
    typedef struct {logic [32:0] cmd; logic rb; logic [16:0] want;} row_s;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [32:0] cmd_word = '0;
    logic trigger_in = 1'b1;
    logic rd_bit = 1'b0;
    logic stall = 1'b0;
    logic cmd_ready, reply_valid, reply_ready, ee_stb, dac_strobe, running;
    logic [32:0] reply_word, last_reply;
    logic [1:0] ee_bits;
    logic [2:0] dac_channel;
    logic [15:0] dac_value;
    int reply_count, n, cnt;
    int ee_count = 0;
    int mismatches = 0;
    int total_checks = 0;
    row_s rows[5];
    dac_module_command_engine DUT (.clock(clock), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
        .reply_valid(reply_valid), .reply_ready(reply_ready),
        .reply_word(reply_word), .trigger_in(trigger_in),
        .eeprom_strobe(ee_stb), .eeprom_bits(ee_bits),
        .eeprom_read_bit(rd_bit), .dac_strobe(dac_strobe),
        .dac_channel(dac_channel), .dac_value(dac_value), .running(running));
    controller_model host (.clock(clock), .rst(rst), .stall(stall),
        .reply_valid(reply_valid), .reply_word(reply_word),
        .reply_ready(reply_ready), .last_reply(last_reply),
        .reply_count(reply_count));
    initial forever #5 clock = ~clock;
    always @(posedge clock) if (ee_stb === 1'b1) ee_count++;
    task tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick
    task check(input logic [32:0] seen, input logic [32:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task send(input logic [32:0] w);
        cmd_word = w;
        cmd_valid = 1'b1;
        for (n = 0; n < 64 && cmd_ready !== 1'b1; n++) tick(1);
        tick(1);
        cmd_valid = 1'b0;
        tick(1);
    endtask : send
    task wait_dac;
        tick(1);
        for (n = 0; n < 600 && dac_strobe !== 1'b1; n++) tick(1);
    endtask : wait_dac
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // watchdog: the tests need about 1700 cycles
    initial begin
        #200000;
        mismatches++;
        final_report;
    end
    initial begin
        tick(8);
        rst = 1'b0;
        tick(2);
        check({30'h0, running, dac_strobe, reply_valid}, 33'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++) rows[i] = '{{1'b1, 6'h18, i[1:0], 24'h0},
            i[0], 17'h16000};
        rows[4] = '{{1'b1, 8'h80, 24'h0}, 1'b0,
            {1'b1, `RPL_IDENT, `FW_VERSION, `MODULE_ID}};
        foreach (rows[i]) begin
            if (i == 4) send({1'b1, 32'h0});
            rd_bit = rows[i].rb;
            cnt = reply_count;
            send(rows[i].cmd);
            tick(3);
            check({16'h0, last_reply[32:16]}, {16'h0, rows[i].want});
            check(33'(reply_count - cnt), 33'h1);
            if (i < 4) check({30'h0, last_reply[0], ee_bits},
                {30'h0, rows[i].rb, rows[i].cmd[25:24]});
        end
        check(33'(ee_count), 33'h4);
        $display("table test done");
        send({1'b1, 8'he0, 8'h08, 16'h3c3c});
        send({1'b0, 8'h06, 8'h00, 16'h1234});
        send({1'b0, 8'h06, 8'h00, 16'h5678});
        send({1'b1, 8'hc0, 24'h0});
        cnt = ee_count;
        send({1'b1, 8'h61, 24'h0});
        check({31'h0, running, 1'(ee_count - cnt)}, 33'h2);
        wait_dac;
        check({14'h0, dac_channel, dac_value}, {14'h0, 3'h3, 16'h1234});
        wait_dac;
        check(33'(n + 1), 33'd200);
        tick(4);
        check({8'h0, last_reply[32:24], last_reply[15:0]}, 33'h1e65678);
        tick(450);
        check({17'h0, dac_value}, 33'h5678);
        send({1'b0, 8'h06, 8'h00, 16'h9abc});
        wait_dac;
        tick(4);
        check({8'h0, last_reply[32:24], last_reply[15:0]}, 33'h1f69abc);
        for (int k = 0; k < 20; k++) send({1'b0, 8'h06, 8'h00, 16'(k)});
        stall = 1'b1;
        wait_dac;
        tick(4);
        check({31'h0, reply_valid, cmd_ready}, 33'h2);
        stall = 1'b0;
        tick(4);
        check({32'h0, last_reply[24]}, 33'h1);
        send({1'b1, 32'h0});
        cnt = reply_count;
        check({32'h0, running}, 33'h0);
        tick(300);
        check(33'(reply_count - cnt), 33'h0);
        $display("stream test done");
        send({1'b1, 8'he0, 8'h0f, 16'h3c3c});
        send({1'b0, 8'h00, 8'h00, 16'h4242});
        cnt = reply_count;
        send({1'b1, 8'hc0, 24'h0});
        tick(20);
        check({32'h0, running}, 33'h0);
        trigger_in = 1'b0;
        for (n = 0; n < 8 && running !== 1'b1; n++) tick(1);
        check({32'h0, running}, 33'h1);
        send({1'b0, 8'h00, 8'h00, 16'h7777});
        wait_dac;
        wait_dac;
        check({16'h0, dac_strobe, dac_value}, 33'h14242);
        check(33'(reply_count - cnt), 33'h0);
        send({1'b1, 32'h0});
        trigger_in = 1'b1;
        $display("ring test done");
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        check({16'h0, running, dac_value}, 33'h0);
        $display("second reset test done");
        final_report;
    end
endmodule : tb_top
`default_nettype wire
